// >>> src/ecmr_top.sv
// Purpose: Monitor and filter tap readout register bank of an echo canceller.
// Assumes: Datapath delivers taps with a valid pulse and monitor bytes per channel.
// Notes:   All registers sit on an eight-bit port with read data one cycle later.
`timescale 1ns/10ps

module ecmr_top
  import ecmr_pkg::*;
(
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_i,
  // Register port.
  input  wire logic [7:0]            reg_addr_i,
  input  wire logic [7:0]            reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic      [7:0]            reg_rdata_o,
  output logic                       irq_o,
  // Tap source from the adaptive filter.
  input  wire logic                  tap_valid_i,
  input  wire logic [ECMR_TAP_W-1:0] tap_value_i,
  input  wire logic [ECMR_AUX_W-1:0] tap_aux_i,
  input  wire logic                  tap_last_i,
  output logic                       tap_ready_o,
  output logic                       tap_run_o,
  output logic      [ECMR_CH_W-1:0]  tap_channel_o,
  output logic      [ECMR_LIN_W-1:0] tap_linear_o,
  // Monitor update from the datapath, one item per pulse.
  input  wire logic                  mon_wr_i,
  input  wire logic [ECMR_CH_W-1:0]  mon_ch_i,
  input  wire logic [3:0]            mon_sel_i,
  input  wire logic [7:0]            mon_data_i,
  output logic      [ECMR_CH_W-1:0]  monitored_channel_number_o,
  output logic      [7:0]            level_log_max_o
);

  // The block is a read-mostly window onto the echo canceller. Monitor
  // bytes arrive from the datapath for every channel and are kept per
  // channel, so the host sees the newest value of whichever channel it
  // selected without the datapath having to know that selection.
  // Filter taps are handed over one at a time under a ready/valid
  // handshake and held until the host acknowledges them or a control write
  // restarts the readout. The datapath therefore never outruns a slow host,
  // and no tap is lost unless a control write comes while it is taken or held.
  // Writes to addresses that hold monitor or tap data change nothing.

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  logic [7:0]           ctrl_r;
  logic [1:0]           irq_stat_r;
  logic [1:0]           irq_mask_r;
  logic [ECMR_CH_W-1:0] mon_ch_r;
  logic                 rd_ack;
  logic                 tap_take;
  logic                 mon_event;
  ecmr_state_e          state_r;
  logic [ECMR_TAP_W-1:0] filter_tap_value_r;
  logic [ECMR_AUX_W-1:0] auxiliary_tap_value_r;
  logic                 final_tap_flag_r;

  // The acknowledge is any read strobe at the tap high address. It does not
  // look at the sequencer state; outside the hold state it only clears a
  // status bit that is already clear, unless a control write came as a tap was taken or held.
  assign rd_ack    = reg_rd_i && (reg_addr_i == ECMR_TDH_ADDR);
  assign mon_event = mon_wr_i && (mon_ch_i == mon_ch_r);

  // Control: run bit and channel; running readout ends on final acknowledge.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_r <= ECMR_CTRL_RST;
    end else if (reg_wr_i && reg_addr_i == ECMR_CTRL_ADDR) begin
      ctrl_r <= {reg_wdata_i[ECMR_CTRL_RUN], 2'h0, reg_wdata_i[ECMR_CH_W-1:0]};
    end else if (rd_ack && state_r == ECMR_HOLD && final_tap_flag_r) begin
      ctrl_r[ECMR_CTRL_RUN] <= 1'b0;
    end
  end

  // Monitored channel select. The stores are read with this value every
  // cycle, so a read strobe two cycles after the write sees the new channel.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mon_ch_r <= '0;
    end else if (reg_wr_i && reg_addr_i == ECMR_STAT_ADDR) begin
      mon_ch_r <= reg_wdata_i[ECMR_CH_W-1:0];
    end
  end

  // Interrupt mask. A cleared bit keeps its status bit off the interrupt
  // line, but the status bit can still be polled.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      irq_mask_r <= ECMR_MASK_RST;
    end else if (reg_wr_i && reg_addr_i == ECMR_IMSK_ADDR) begin
      irq_mask_r <= reg_wdata_i[1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Tap readout sequencer
  // ----------------------------------------------------------------------
  // A tap is taken only while running and nothing is pending, so the next
  // tap waits until the host has acknowledged the present one or has restarted the readout with a control write.
  assign tap_take    = (state_r == ECMR_WAIT) && tap_valid_i;
  assign tap_ready_o = (state_r == ECMR_WAIT);
  assign tap_run_o   = ctrl_r[ECMR_CTRL_RUN];
  assign tap_channel_o = ctrl_r[ECMR_CH_W-1:0];

  // Sequencer state; any control write restarts the readout.
  // Idle means no readout, wait means ready for the next tap and hold
  // means a tap is on show until the host reads the high byte. A final tap
  // returns to idle, so the datapath sees ready drop for good.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= ECMR_IDLE;
    end else if (reg_wr_i && reg_addr_i == ECMR_CTRL_ADDR) begin
      state_r <= reg_wdata_i[ECMR_CTRL_RUN] ? ECMR_WAIT : ECMR_IDLE;
    end else begin
      case (state_r)
        ECMR_IDLE: state_r <= ECMR_IDLE;
        ECMR_WAIT: if (tap_take) begin
          state_r <= ECMR_HOLD;
        end
        ECMR_HOLD: if (rd_ack) begin
          state_r <= final_tap_flag_r ? ECMR_IDLE : ECMR_WAIT;
        end
        default:   state_r <= ECMR_IDLE;
      endcase
    end
  end

  // Capture the presented tap. The three fields are taken in the same
  // cycle, so the high, low and auxiliary bytes always belong together
  // however long the host takes between its reads.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      filter_tap_value_r    <= '0;
      auxiliary_tap_value_r <= '0;
      final_tap_flag_r      <= 1'b0;
    end else if (tap_take) begin
      filter_tap_value_r    <= tap_value_i;
      auxiliary_tap_value_r <= tap_aux_i;
      final_tap_flag_r      <= tap_last_i;
    end
  end

  // ----------------------------------------------------------------------
  // Tap expansion to linear value
  // ----------------------------------------------------------------------
  logic [2:0]            tap_exp;
  logic [ECMR_LIN_W-2:0] tap_mag;
  assign tap_exp = filter_tap_value_r[12:10];

  // The stored tap is a small float: sign, three exponent bits and a ten
  // bit mantissa. The magnitude needs seventeen bits at the largest
  // exponent, which leaves the top bit of the linear word for the sign.
  // Exponent zero keeps the mantissa; otherwise an implied one sits at 9+e.
  always_comb begin
    tap_mag = {7'h00, filter_tap_value_r[ECMR_MANT_W-1:0]};
    if (tap_exp != 3'h0) begin
      tap_mag = ({7'h01, filter_tap_value_r[ECMR_MANT_W-1:0]}
                 << (tap_exp - 3'h1));
    end
  end

  // Registered linear output with the sign on top.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tap_linear_o <= '0;
    end else begin
      tap_linear_o <= {filter_tap_value_r[ECMR_SIGN_BIT], tap_mag};
    end
  end

  // Largest log code as a constant reference for the datapath.
  // It reads zero while reset is applied and the full-scale code after,
  // so a datapath can tell a live block from one still held in reset.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      level_log_max_o <= 8'h00;
    end else begin
      level_log_max_o <= ECMR_LOG_MAX;
    end
  end

  assign monitored_channel_number_o = mon_ch_r;

  // ----------------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------------
  // Events set, write-one clears; a set in the same cycle wins. The tap bit
  // also clears on the acknowledging read unless a new tap lands then.
  // The monitor bit is only set by updates for the selected channel, so
  // traffic for other channels never disturbs the host.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      irq_stat_r <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == ECMR_IRQ_TAP && tap_take) || (i == ECMR_IRQ_MON && mon_event)) begin
          irq_stat_r[i] <= 1'b1;
        end else if (reg_wr_i && reg_addr_i == ECMR_IST_ADDR && reg_wdata_i[i]) begin
          irq_stat_r[i] <= 1'b0;
        end else if (i == ECMR_IRQ_TAP && rd_ack) begin
          irq_stat_r[i] <= 1'b0;
        end
      end
    end
  end

  assign irq_o = |(irq_stat_r & irq_mask_r);

  // ----------------------------------------------------------------------
  // Monitor stores, one per monitored quantity
  // ----------------------------------------------------------------------
  localparam int NMON = 12;
  localparam logic [7:0] MON_ADDR [NMON] = '{
    ECMR_SIL_ADDR, ECMR_SOL_ADDR, ECMR_RIL_ADDR, ECMR_OFSI_ADDR,
    ECMR_OFSO_ADDR, ECMR_AEL_ADDR, ECMR_BNL_ADDR, ECMR_ERL_ADDR,
    ECMR_CL_ADDR, ECMR_SI_ADDR, ECMR_SO_ADDR, ECMR_RI_ADDR};
  // Valid bits per item: offsets six, noise seven, all others eight.
  localparam logic [7:0] MON_MASK [NMON] = '{
    8'hff, 8'hff, 8'hff, 8'h3f, 8'h3f, 8'hff,
    8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};

  logic [7:0] mon_q [NMON];

  // One store per monitored quantity. Every store is read with the selected
  // channel all the time, and masking on the write side keeps the unused
  // upper bits of the offset and noise items at zero in storage.

  for (genvar g = 0; g < NMON; g++) begin : g_mon
    ecmr_chan_mem u_mem (
      .clk_sys_i (clk_sys_i),
      .wr_en_i   (mon_wr_i && mon_sel_i == 4'(g)),
      .wr_ch_i   (mon_ch_i),
      .wr_data_i (mon_data_i & MON_MASK[g]),
      .rd_ch_i   (mon_ch_r),
      .rd_data_o (mon_q[g])
    );
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  // The answer is chosen from the address beside the read strobe and then
  // registered, so it stands for exactly the cycle after the strobe. Every
  // source is a register or a store with registered output, which keeps
  // the path from the strobe edge to the pins one flop deep.
  logic [7:0] rd_mux;

  // Select the answer; monitor bytes pass through unchanged, so level and
  // loss codes stay logarithmic, samples stay companded and offsets stay
  // in ones complement. Unmapped addresses answer zero.
  always_comb begin
    rd_mux = ECMR_UNMAPPED;
    case (reg_addr_i)
      ECMR_TDH_ADDR:  rd_mux = filter_tap_value_r[13:6];
      ECMR_TDL_ADDR:  rd_mux = {final_tap_flag_r, 1'b0, filter_tap_value_r[5:0]};
      ECMR_AUX_ADDR:  rd_mux = auxiliary_tap_value_r[9:2];
      ECMR_CTRL_ADDR: rd_mux = ctrl_r;
      ECMR_IST_ADDR:  rd_mux = {6'h00, irq_stat_r};
      ECMR_IMSK_ADDR: rd_mux = {6'h00, irq_mask_r};
      ECMR_STAT_ADDR: rd_mux = {3'h0, mon_ch_r};
      default: begin
        for (int k = 0; k < NMON; k++) begin
          if (reg_addr_i == MON_ADDR[k]) begin
            rd_mux = mon_q[k] & MON_MASK[k];
          end
        end
      end
    endcase
  end

  // Read data register; zero whenever no read was asked for, so a value
  // left over from an earlier read can never be taken for a new answer.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_mux;
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

endmodule : ecmr_top

// >>> src/ecmr_pkg.sv
// Purpose: Shared constants for the echo canceller monitor readout block.
// Assumes: Eight-bit register port, byte offsets as printed.
// Notes:   Own registers sit in a free range above the monitor set.
package ecmr_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ECMR_SIL_ADDR  = 8'h1e;
  localparam logic [7:0] ECMR_SOL_ADDR  = 8'h1f;
  localparam logic [7:0] ECMR_RIL_ADDR  = 8'h20;
  localparam logic [7:0] ECMR_OFSI_ADDR = 8'h21;
  localparam logic [7:0] ECMR_OFSO_ADDR = 8'h22;
  localparam logic [7:0] ECMR_AEL_ADDR  = 8'h23;
  localparam logic [7:0] ECMR_BNL_ADDR  = 8'h24;
  localparam logic [7:0] ECMR_ERL_ADDR  = 8'h25;
  localparam logic [7:0] ECMR_CL_ADDR   = 8'h26;
  localparam logic [7:0] ECMR_SI_ADDR   = 8'h29;
  localparam logic [7:0] ECMR_SO_ADDR   = 8'h2a;
  localparam logic [7:0] ECMR_RI_ADDR   = 8'h2b;
  localparam logic [7:0] ECMR_TDH_ADDR  = 8'h7b;
  localparam logic [7:0] ECMR_TDL_ADDR  = 8'h7c;
  localparam logic [7:0] ECMR_AUX_ADDR  = 8'h7d;
  localparam logic [7:0] ECMR_CTRL_ADDR = 8'h80;
  localparam logic [7:0] ECMR_IST_ADDR  = 8'h81;
  localparam logic [7:0] ECMR_IMSK_ADDR = 8'h82;
  localparam logic [7:0] ECMR_STAT_ADDR = 8'h83;

  // ----------------------------------------------------------------------
  // Field positions, widths and reset values
  // ----------------------------------------------------------------------
  localparam int         ECMR_NCH        = 32;
  localparam int         ECMR_CH_W       = 5;
  localparam int         ECMR_TAP_W      = 14;
  localparam int         ECMR_LIN_W      = 18;
  localparam int         ECMR_AUX_W      = 10;
  localparam int         ECMR_MANT_W     = 10;
  localparam int         ECMR_SIGN_BIT   = 13;
  localparam int         ECMR_IRQ_TAP    = 0;
  localparam int         ECMR_IRQ_MON    = 1;
  localparam int         ECMR_CTRL_RUN   = 7;
  localparam logic [7:0] ECMR_CTRL_RST   = 8'h00;
  localparam logic [1:0] ECMR_MASK_RST   = 2'h0;
  localparam logic [7:0] ECMR_LOG_MAX    = 8'hbf;
  localparam logic [7:0] ECMR_LOG_ZERO   = 8'hb8;
  localparam logic [7:0] ECMR_UNMAPPED   = 8'h00;

  typedef enum logic [1:0] {
    ECMR_IDLE,
    ECMR_WAIT,
    ECMR_HOLD
  } ecmr_state_e;

endpackage : ecmr_pkg

// >>> src/ecmr_chan_mem.sv
// Purpose: Per-channel monitor store, one byte per channel, registered read.
// Assumes: One write and one read port on the system clock.
// Notes:   Read data lag the read address by one cycle.
`timescale 1ns/10ps
module ecmr_chan_mem
  import ecmr_pkg::*;
(
  input  wire logic                 clk_sys_i,
  input  wire logic                 wr_en_i,
  input  wire logic [ECMR_CH_W-1:0] wr_ch_i,
  input  wire logic [7:0]           wr_data_i,
  input  wire logic [ECMR_CH_W-1:0] rd_ch_i,
  output logic      [7:0]           rd_data_o
);

  logic [7:0] mem [ECMR_NCH];

  // Store the newest value for a channel.
  always_ff @(posedge clk_sys_i) begin
    if (wr_en_i) begin
      mem[wr_ch_i] <= wr_data_i;
    end
  end

  // Register the selected channel's value.
  always_ff @(posedge clk_sys_i) begin
    rd_data_o <= mem[rd_ch_i];
  end

endmodule : ecmr_chan_mem

// >>> dv/ecmr_top_asserts.sv
// Purpose: Port-level checks for the monitor readout register bank.
// Assumes: Hold state shows as tap_run_o high with tap_ready_o low.
// Notes:   Helper flops mirror the mask and the captured tap.
`timescale 1ns/10ps
module ecmr_chk
  import ecmr_pkg::*;
(
  input wire logic                  clk_sys_i,
  input wire logic                  rst_i,
  input wire logic [7:0]            reg_addr_i,
  input wire logic [7:0]            reg_wdata_i,
  input wire logic                  reg_wr_i,
  input wire logic                  reg_rd_i,
  input wire logic [7:0]            reg_rdata_o,
  input wire logic                  irq_o,
  input wire logic                  tap_valid_i,
  input wire logic [ECMR_TAP_W-1:0] tap_value_i,
  input wire logic [ECMR_AUX_W-1:0] tap_aux_i,
  input wire logic                  tap_last_i,
  input wire logic                  tap_ready_o,
  input wire logic                  tap_run_o,
  input wire logic [ECMR_LIN_W-1:0] tap_linear_o,
  input wire logic [ECMR_CH_W-1:0]  monitored_channel_number_o,
  input wire logic [7:0]            level_log_max_o
);
  logic [1:0]  msk_q;
  logic [13:0] tv_q;
  logic [9:0]  ax_q;
  logic        lst_q;
  logic [7:0]  wd_q;
  wire tk   = tap_valid_i && tap_ready_o;
  wire hold = tap_run_o && !tap_ready_o;
  wire ack  = reg_rd_i && (reg_addr_i == ECMR_TDH_ADDR) && hold;

  // Mask copy follows host writes to the mask register.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) msk_q <= ECMR_MASK_RST;
    else if (reg_wr_i && reg_addr_i == ECMR_IMSK_ADDR) msk_q <= reg_wdata_i[1:0];
  end

  // Captured tap and last write data, kept for later comparison.
  always_ff @(posedge clk_sys_i) begin
    wd_q <= reg_wdata_i;
    if (tk) {lst_q, ax_q, tv_q} <= {tap_last_i, tap_aux_i, tap_value_i};
  end

  // Expands the float tap: implied one sits at bit 9 plus the exponent.
  function automatic logic [17:0] lin_f(input logic [13:0] v);
    logic [17:0] m;
    m = (v[12:10] == 3'h0) ? {8'h00, v[9:0]} : ({7'h00, 1'b1, v[9:0]} << (v[12:10] - 3'h1));
    m[17] = v[13];
    return m;
  endfunction : lin_f

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  property p_idle; !reg_rd_i |=> reg_rdata_o == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data not zero without a read");
  property p_take; tk |=> !tap_ready_o; endproperty
  a_take: assert property (p_take) else $error("second tap taken before acknowledge");
  property p_hold; hold && !ack && !(reg_wr_i && reg_addr_i == ECMR_CTRL_ADDR) |=> hold; endproperty
  a_hold: assert property (p_hold) else $error("hold left without acknowledge");
  property p_rearm; ack |=> (lst_q ? !tap_run_o : tap_ready_o); endproperty
  a_rearm: assert property (p_rearm) else $error("acknowledge did not re-arm or stop");
  property p_irq; tk && msk_q[0] |=> irq_o; endproperty
  a_irq: assert property (p_irq) else $error("tap interrupt not raised");
  property p_ackirq; ack && msk_q == 2'h1 |=> !irq_o; endproperty
  a_ackirq: assert property (p_ackirq) else $error("tap interrupt not cleared");
  property p_hi; ack |=> reg_rdata_o == tv_q[13:6]; endproperty
  a_hi: assert property (p_hi) else $error("tap high byte wrong");
  property p_lo;
    reg_rd_i && reg_addr_i == ECMR_TDL_ADDR && hold |=> reg_rdata_o == {lst_q, 1'b0, tv_q[5:0]};
  endproperty
  a_lo: assert property (p_lo) else $error("tap low byte wrong");
  property p_aux; reg_rd_i && reg_addr_i == ECMR_AUX_ADDR && hold |=> reg_rdata_o == ax_q[9:2]; endproperty
  a_aux: assert property (p_aux) else $error("auxiliary byte wrong");
  property p_lin; tk |=> ##1 tap_linear_o == lin_f(tv_q); endproperty
  a_lin: assert property (p_lin) else $error("linear tap value wrong");
  property p_mch; reg_wr_i && reg_addr_i == ECMR_STAT_ADDR |=> monitored_channel_number_o == wd_q[4:0]; endproperty
  a_mch: assert property (p_mch) else $error("monitored channel not taken");
  property p_max; !$past(rst_i) |-> level_log_max_o == ECMR_LOG_MAX; endproperty
  a_max: assert property (p_max) else $error("log maximum code wrong");

  c_take: cover property (tk);
  c_last: cover property (ack && lst_q);
  c_irq: cover property ($rose(irq_o));
endmodule : ecmr_chk

bind ecmr_top ecmr_chk chk_u (.clk_sys_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
  .reg_rdata_o, .irq_o, .tap_valid_i, .tap_value_i, .tap_aux_i, .tap_last_i, .tap_ready_o,
  .tap_run_o, .tap_linear_o, .monitored_channel_number_o, .level_log_max_o);

// >>> dv/ecmr_host.sv
// Purpose: Host processor model that reads and writes the register bank.
// Assumes: Tasks are entered just after a rising edge.
// Notes:   Every task returns at a rising edge with the strobes low.
`timescale 1ns/10ps
module ecmr_host
  import ecmr_pkg::*;
(
  input  wire logic       clk_sys_i,
  output logic      [7:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  input  wire logic [7:0] reg_rdata_i
);
  // Idle bus at time zero.
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end

  // One-cycle write strobe.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_o <= 1'b0;
    @(posedge clk_sys_i);
  endtask : wr

  // One-cycle read strobe, data taken in the following cycle.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_o <= 1'b0;
    @(negedge clk_sys_i);
    d = reg_rdata_i;
    @(posedge clk_sys_i);
  endtask : rd

  // Tap fetch reads the acknowledging high byte last.
  task automatic tap_rd(output logic [7:0] lo, output logic [7:0] ax, output logic [7:0] hi);
    rd(ECMR_TDL_ADDR, lo);
    rd(ECMR_AUX_ADDR, ax);
    rd(ECMR_TDH_ADDR, hi);
  endtask : tap_rd

  // Clears the monitor update flag with a write-one to the status register.
  task automatic mon_clr();
    wr(ECMR_IST_ADDR, 8'h02);
  endtask : mon_clr
endmodule : ecmr_host

// >>> dv/ecmr_top_bench.sv
// Purpose: Self-checking bench for the monitor readout register bank.
// Assumes: Host model drives the register port, bench drives the datapath.
// Notes:   Monitor contents are mirrored in an integer array.
`timescale 1ns/10ps
module ecmr_top_bench;
  import ecmr_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  addr, wdata, rdata, d, lo, ax, hi, mdat, lmax;
  logic        wr, rd, irq, tv, tl, trdy, trun, mwr;
  logic [13:0] tval;
  logic [9:0]  taux;
  logic [4:0]  tch, monitored_channel_number, mchan, mon_ch;
  logic [3:0]  msel;
  logic [17:0] tlin;
  logic [31:0] seed = 32'd21;
  logic [31:0] c;
  int          n_mismatch = 0;
  int          checked = 0;
  int          mm[32][12];
  int          n;
  int          mag;

  always #2.5 clk_sys_i = ~clk_sys_i;

  ecmr_host host_u (.clk_sys_i(clk_sys_i), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr),
    .reg_rd_o(rd), .reg_rdata_i(rdata));
  ecmr_top dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .irq_o(irq), .tap_valid_i(tv),
    .tap_value_i(tval), .tap_aux_i(taux), .tap_last_i(tl), .tap_ready_o(trdy), .tap_run_o(trun),
    .tap_channel_o(tch), .tap_linear_o(tlin), .mon_wr_i(mwr), .mon_ch_i(monitored_channel_number), .mon_sel_i(msel),
    .mon_data_i(mdat), .monitored_channel_number_o(mon_ch), .level_log_max_o(lmax));

  // Xorshift source of stimulus values.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Compares one value and counts the result.
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  // Writes one monitor item and mirrors it in the model.
  task automatic mon_put(input logic [4:0] ch, input int s, input logic [7:0] v);
    mwr <= 1'b1;
    monitored_channel_number <= ch;
    msel <= s[3:0];
    mdat <= v;
    mm[ch][s] = v;
    @(posedge clk_sys_i);
    mwr <= 1'b0;
    @(posedge clk_sys_i);
  endtask : mon_put

  // Main sequence: reset values, monitors, then a full tap readout.
  initial begin
    {tv, tl, mwr, tval, taux, monitored_channel_number, msel, mdat} = '0;
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    for (int i = 0; i < 3; i++) begin
      host_u.rd(ECMR_CTRL_ADDR + 8'(i), d);
      chk(d, 8'h00);
    end
    host_u.rd(8'h50, d);
    chk(d, ECMR_UNMAPPED);
    chk(lmax, 8'd191);
    c = rnd();
    mchan = c[4:0];
    host_u.wr(ECMR_STAT_ADDR, {3'h0, mchan});
    chk(mon_ch, mchan);
    for (int s = 0; s < 12; s++) mon_put(mchan, s, 8'(rnd()));
    chk(irq, 1'b0);
    host_u.wr(ECMR_IMSK_ADDR, 8'h02);
    chk(irq, 1'b1);
    host_u.mon_clr();
    chk(irq, 1'b0);
    for (int s = 0; s < 12; s++) mon_put(mchan ^ 5'h01, s, 8'(rnd()));
    chk(irq, 1'b0);
    for (int s = 0; s < 12; s++) begin
      host_u.rd((s < 9) ? 8'h1e + 8'(s) : 8'h20 + 8'(s), d);
      c = (s == 3 || s == 4) ? 32'h3f : (s == 6) ? 32'h7f : 32'hff;
      chk(d, 8'(mm[mchan][s]) & c[7:0]);
    end
    mon_put(mchan, 0, ECMR_LOG_ZERO);
    mon_put(mchan, 1, 8'h00);
    host_u.rd(ECMR_SIL_ADDR, d);
    chk(d, 8'd184);
    host_u.rd(ECMR_SOL_ADDR, d);
    chk(d, 8'd0);
    host_u.mon_clr();
    host_u.wr(ECMR_IMSK_ADDR, 8'h01);
    host_u.wr(ECMR_CTRL_ADDR, {3'h4, ~mchan});
    chk(tch, {~mchan});
    for (int i = 0; i < 8; i++) begin
      n = 0;
      while (trdy !== 1'b1 && n < 20) begin
        @(posedge clk_sys_i);
        n++;
      end
      if (trdy !== 1'b1) begin
        n_mismatch++;
        wrap_up();
      end
      c = rnd();
      tv <= 1'b1;
      tval <= {c[13], 3'(i), c[9:0]};
      taux <= c[25:16];
      tl <= (i == 7);
      @(posedge clk_sys_i);
      tv <= 1'b0;
      @(posedge clk_sys_i);
      chk(irq, 1'b1);
      host_u.wr(ECMR_TDH_ADDR, 8'hff);
      host_u.tap_rd(lo, ax, hi);
      chk(lo, {i == 7, 1'b0, c[5:0]});
      chk(ax, c[25:18]);
      chk(hi, {c[13], 3'(i), c[9:6]});
      chk(irq, 1'b0);
      mag = (i == 0) ? int'(c[9:0]) : (1024 + int'(c[9:0])) << (i - 1);
      chk(tlin, {c[13], 17'(mag)});
    end
    chk(trun, 1'b0);
    wrap_up();
  end
endmodule : ecmr_top_bench
